// ### coz_pkg.sv
package coz_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0]  CHARGE_OPTION_ZERO_ADDR = 8'h12;
	localparam logic [15:0] CHARGE_OPTION_ZERO_RST  = 16'hE70E;
	localparam logic [15:0] CHARGE_OPTION_ZERO_MASK = 16'hFFFF;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_CHARGE_BLOCK      = 0;
	localparam int BIT_INPUT_LOOP_EN     = 1;
	localparam int BIT_LINEAR_PRECHARGE  = 2;
	localparam int BIT_BAT_AMP_GAIN      = 3;
	localparam int BIT_IN_AMP_GAIN       = 4;
	localparam int BIT_LEARN_EN          = 5;
	localparam int BIT_SHORT_HICCUP_OFF  = 6;
	localparam int BIT_BYPASS_RIPPLE     = 8;
	localparam int BIT_SWITCHING_FREQ    = 9;
	localparam int BIT_INPUT_LOOP_AUTO   = 12;

	// ---------------------------------------------------------------
	// analog figures handed to the power stage
	// ---------------------------------------------------------------
	localparam logic [11:0] FREQ_HIGH_KHZ       = 12'h4B0; // 1200 kHz
	localparam logic [11:0] FREQ_LOW_KHZ        = 12'h320; // 800 kHz
	localparam logic [5:0]  IN_GAIN_LOW         = 6'h14;   // 20x
	localparam logic [5:0]  IN_GAIN_HIGH        = 6'h28;   // 40x
	localparam logic [5:0]  BAT_GAIN_LOW        = 6'h08;   // 8x
	localparam logic [5:0]  BAT_GAIN_HIGH       = 6'h10;   // 16x
	localparam logic [11:0] PRECHARGE_CLAMP_MULTI_MA  = 12'h180; // 384 mA
	localparam logic [11:0] PRECHARGE_CLAMP_SINGLE_MA = 12'h7D0; // 2000 mA
	localparam logic [11:0] HICCUP_SYS_MV       = 12'h960; // 2.4 V

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        wr_en;
		logic        rd_en;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} coz_req_t;

	typedef struct packed {
		logic [11:0] switching_freq_khz;
		logic        bypass_ripple_reduce;
		logic        hiccup_enable;
		logic        learn_discharge;
		logic [5:0]  input_current_amp_gain;
		logic [5:0]  battery_current_amp_gain;
		logic        precharge_active;
		logic        linear_precharge;
		logic        battery_switch_full_on;
		logic        regulate_to_min_sys;
		logic [11:0] precharge_clamp_ma;
		logic        input_loop_active;
		logic        charge_allowed;
	} coz_ctl_t;

	typedef struct packed {
		logic bat_present_meta;
		logic bat_present_sync;
		logic bat_present_prev;
	} coz_sync_t;

	typedef struct packed {
		logic [15:0] option;
		logic [15:0] rdata;
		logic        rvalid;
	} coz_state_t;

endpackage : coz_pkg

// ### coz_pin_sync.sv
`timescale 1ns/1ps

module coz_pin_sync
	import coz_pkg::*;
(
	input  wire logic clock,    // system clock
	input  wire logic rst,      // async reset, high
	input  wire logic pin_in,   // raw battery-present pin
	output logic      pin_low,  // synced level, pin low
	output logic      fall      // one-cycle pulse on falling edge
);

	coz_sync_t state;
	coz_sync_t next_state;

	always_comb begin
		next_state                  = state;
		next_state.bat_present_meta = pin_in;
		next_state.bat_present_sync = state.bat_present_meta;
		next_state.bat_present_prev = state.bat_present_sync;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '{1'b1, 1'b1, 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign pin_low = !state.bat_present_sync;
	assign fall    = state.bat_present_prev && !state.bat_present_sync;

endmodule : coz_pin_sync

// ### coz_charge_option.sv
// How it works
// - bit 9 resets to 1; writing 0 selects 1200 kHz switching.
// - bit 8, reset 1, enables bypass ripple reduction; 0 disables it.
// - bit 6 clear gives hiccup below 2.4 V; set suppresses hiccup.
// - bit 5 enables learn discharge; battery pin low clears it.
// - bit 4 selects input amplifier gain 20x at 0, 40x at 1.
// - bit 3 selects battery amplifier gain 8x at 0, 16x at 1.
// - battery below minimum system voltage means precharge, linear if enabled.
// - linear precharge: clamp 384 mA multi-cell or 2 A single cell.
// - linear precharge off: switch full on, regulate to max charge voltage.
// - bit 1 resets to 1 enabling input loop; auto-disable clears it.
// - bit 0 clear allows charging with valid settings; set inhibits.
// - auto-clear of input loop on pin falling edge only when bit 12 set.
`timescale 1ns/1ps

module coz_charge_option
	import coz_pkg::*;
(
	input  wire logic   clock,               // 10 MHz system clock
	input  wire logic   rst,                 // async reset, high
	input  wire coz_req_t req,               // register access from smbus
	output logic [15:0] rdata,               // read data, registered
	output logic        rvalid,              // read data valid pulse
	input  wire logic   battery_present_pin, // battery present, low = absent
	input  wire logic   bat_below_min_sys,   // battery under min system level
	input  wire logic   single_cell,         // pack is one cell
	input  wire logic   settings_valid,      // charge voltage/current valid
	input  wire logic   sys_below_hiccup,    // system rail under hiccup level
	input  wire logic   bypass_operation,    // converter in bypass
	output coz_ctl_t    ctl,                 // decoded controls to power stage
	output logic [15:0] option_value         // live register contents
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	coz_state_t state;
	coz_state_t next_state;
	logic       pin_low;
	logic       pin_fall;
	logic       hit;

	coz_pin_sync u_sync (
		.clock   (clock),
		.rst     (rst),
		.pin_in  (battery_present_pin),
		.pin_low (pin_low),
		.fall    (pin_fall)
	);

	assign hit = (req.addr == CHARGE_OPTION_ZERO_ADDR);

	// ---------------------------------------------------------------
	// register update
	// ---------------------------------------------------------------
	always_comb begin
		next_state        = state;
		next_state.rvalid = 1'b0;
		if (req.wr_en && hit) begin
			next_state.option = req.wdata & CHARGE_OPTION_ZERO_MASK;
		end
		// battery absent ends learn mode
		if (pin_low) begin
			next_state.option[BIT_LEARN_EN] = 1'b0;
		end
		// auto-disable of input loop; host may re-enable later
		if (pin_fall && state.option[BIT_INPUT_LOOP_AUTO]) begin
			next_state.option[BIT_INPUT_LOOP_EN] = 1'b0;
		end
		if (req.rd_en) begin
			next_state.rvalid = 1'b1;
			next_state.rdata  = hit ? state.option : 16'h0000;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state.option <= CHARGE_OPTION_ZERO_RST;
			state.rdata  <= 16'h0000;
			state.rvalid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata        = state.rdata;
	assign rvalid       = state.rvalid;
	assign option_value = state.option;

	// ---------------------------------------------------------------
	// control decode
	// ---------------------------------------------------------------
	logic [15:0] opt;
	assign opt = state.option;

	always_comb begin
		ctl.switching_freq_khz = opt[BIT_SWITCHING_FREQ] ?
			FREQ_LOW_KHZ : FREQ_HIGH_KHZ;
		ctl.bypass_ripple_reduce = bypass_operation &&
			opt[BIT_BYPASS_RIPPLE];
		ctl.hiccup_enable = sys_below_hiccup &&
			!opt[BIT_SHORT_HICCUP_OFF];
		ctl.learn_discharge = opt[BIT_LEARN_EN] && !pin_low;
		ctl.input_current_amp_gain = opt[BIT_IN_AMP_GAIN] ?
			IN_GAIN_HIGH : IN_GAIN_LOW;
		ctl.battery_current_amp_gain = opt[BIT_BAT_AMP_GAIN] ?
			BAT_GAIN_HIGH : BAT_GAIN_LOW;
		ctl.precharge_active = bat_below_min_sys;
		ctl.linear_precharge = bat_below_min_sys &&
			opt[BIT_LINEAR_PRECHARGE];
		ctl.battery_switch_full_on = !opt[BIT_LINEAR_PRECHARGE];
		ctl.regulate_to_min_sys = opt[BIT_LINEAR_PRECHARGE];
		ctl.precharge_clamp_ma = single_cell ?
			PRECHARGE_CLAMP_SINGLE_MA : PRECHARGE_CLAMP_MULTI_MA;
		ctl.input_loop_active = opt[BIT_INPUT_LOOP_EN];
		ctl.charge_allowed = settings_valid &&
			!opt[BIT_CHARGE_BLOCK];
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_fall_armed;
		pin_fall && state.option[BIT_INPUT_LOOP_AUTO];
	endsequence

	a_reset_value: assert property (@(posedge clock)
		$fell(rst) |-> state.option == CHARGE_OPTION_ZERO_RST)
		else $error("option register reset value wrong");

	a_freq_select: assert property (@(posedge clock) disable iff (rst)
		ctl.switching_freq_khz == (opt[BIT_SWITCHING_FREQ] ?
		FREQ_LOW_KHZ : FREQ_HIGH_KHZ))
		else $error("switching frequency decode wrong");

	a_learn_clear: assert property (@(posedge clock) disable iff (rst)
		pin_low |=> !state.option[BIT_LEARN_EN])
		else $error("learn not cleared on battery absent");

	a_loop_autooff: assert property (@(posedge clock) disable iff (rst)
		s_fall_armed |=> !state.option[BIT_INPUT_LOOP_EN])
		else $error("input loop not auto cleared");

	a_loop_kept: assert property (@(posedge clock) disable iff (rst)
		(pin_fall && !state.option[BIT_INPUT_LOOP_AUTO] &&
		state.option[BIT_INPUT_LOOP_EN] && !req.wr_en)
		|=> state.option[BIT_INPUT_LOOP_EN])
		else $error("input loop cleared without auto enable");

	a_write_store: assert property (@(posedge clock) disable iff (rst)
		(req.wr_en && hit && !pin_low && !pin_fall)
		|=> state.option == $past(req.wdata))
		else $error("write not stored");

	a_inhibit_gate: assert property (@(posedge clock) disable iff (rst)
		opt[BIT_CHARGE_BLOCK] |-> !ctl.charge_allowed)
		else $error("charge allowed while inhibited");

	a_hiccup_gate: assert property (@(posedge clock) disable iff (rst)
		ctl.hiccup_enable |-> sys_below_hiccup &&
		!opt[BIT_SHORT_HICCUP_OFF])
		else $error("hiccup decode wrong");

	a_gain_decode: assert property (@(posedge clock) disable iff (rst)
		ctl.battery_current_amp_gain == (opt[BIT_BAT_AMP_GAIN] ?
		BAT_GAIN_HIGH : BAT_GAIN_LOW))
		else $error("battery gain decode wrong");

	a_read_answer: assert property (@(posedge clock) disable iff (rst)
		(req.rd_en && hit) |=> rvalid && rdata == $past(state.option))
		else $error("read answer wrong");

endmodule : coz_charge_option

// ### coz_host_model.sv
`timescale 1ns/1ps

module coz_host_model
	import coz_pkg::*;
(
	input  wire logic clock, // system clock
	output coz_req_t  req    // register request to the device
);
	// ---------------------------------------------------------------
	// host bus cycles, one clock each, launched on falling edges
	// ---------------------------------------------------------------
	// returning the system to adapter after learn has no port effect
	initial req = '0;

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clock);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clock);
		req <= '{1'b0, 1'b0, ~a, ~d}; // released lines carry junk
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		req <= '{1'b0, 1'b1, a, 16'hA5C3};
		@(negedge clock);
		req <= '{1'b0, 1'b0, ~a, 16'h5A3C};
	endtask : rd
endmodule : coz_host_model

// ### charge_option_low_byte_controls_tb.sv
`timescale 1ns/1ps

module charge_option_low_byte_controls_tb;
	import coz_pkg::*;
	logic        clock = 0, rst = 1, pin = 1, below = 0, single = 0;
	logic        valid = 1, sysl = 0, byp = 0, rvalid;
	logic [15:0] rdata, option_value, d;
	coz_req_t    req;
	coz_ctl_t    ctl;
	int          fail_count = 0, check_count = 0, cycles = 0;
	int          seed = 32'h46e4c06e;

	always #50 clock = ~clock;

	coz_host_model u_host (.clock(clock), .req(req));
	coz_charge_option u_dut (.clock(clock), .rst(rst), .req(req),
		.rdata(rdata), .rvalid(rvalid), .battery_present_pin(pin),
		.bat_below_min_sys(below), .single_cell(single),
		.settings_valid(valid), .sys_below_hiccup(sysl),
		.bypass_operation(byp), .ctl(ctl), .option_value(option_value));

	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		check_count++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask : chk

	task automatic b1(input logic got, input logic want);
		chk({15'h0, got}, {15'h0, want});
	endtask : b1

	task automatic ctlchk(input logic [15:0] e);
		chk({4'h0, ctl.switching_freq_khz},
			e[9] ? 16'h0320 : 16'h04B0);
		chk({10'h0, ctl.input_current_amp_gain},
			e[4] ? 16'h0028 : 16'h0014);
		chk({10'h0, ctl.battery_current_amp_gain},
			e[3] ? 16'h0010 : 16'h0008);
		b1(ctl.charge_allowed, ~e[0] & valid);
		b1(ctl.bypass_ripple_reduce, byp & e[8]);
		b1(ctl.hiccup_enable, sysl & ~e[6]);
		b1(ctl.learn_discharge, e[5] & pin);
		b1(ctl.precharge_active, below);
		b1(ctl.linear_precharge, below & e[2]);
		b1(ctl.battery_switch_full_on, ~e[2]);
		b1(ctl.regulate_to_min_sys, e[2]);
		b1(ctl.input_loop_active, e[1]);
		chk({4'h0, ctl.precharge_clamp_ma},
			single ? 16'h07D0 : 16'h0180);
	endtask : ctlchk

	task automatic rdchk(input logic [7:0] a, input logic [15:0] want);
		u_host.rd(a);
		chk({15'h0, rvalid}, 16'h0001);
		chk(rdata, want);
	endtask : rdchk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		@(negedge clock) rst = 0;
		rdchk(8'h12, 16'hE70E);
		ctlchk(16'hE70E);
		rdchk(8'h34, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			d = 16'($random(seed));
			{valid, below, single, sysl, byp} = 5'($random(seed));
			u_host.wr(8'h12, d);
			@(negedge clock);
			chk(option_value, d);
			ctlchk(d);
			rdchk(8'h12, d);
		end
		u_host.wr(8'h55, ~d);
		@(negedge clock);
		chk(option_value, d);
		$display("test random access done");
		u_host.wr(8'h12, 16'h1026);
		pin = 0;
		repeat (5) @(negedge clock);
		chk(option_value, 16'h1004);
		u_host.wr(8'h12, 16'h0022);
		@(negedge clock);
		chk(option_value, 16'h0002);
		pin = 1;
		repeat (4) @(negedge clock);
		pin = 0;
		repeat (5) @(negedge clock);
		chk(option_value, 16'h0002);
		$display("test battery pin done");
		wrap_up();
	end
endmodule : charge_option_low_byte_controls_tb
